// *** pkg/rrw_pkg.sv ***
package rrw_pkg;

  // ----------------------------------------
  // Bus and word indices
  // ----------------------------------------
  localparam int unsigned RRW_ADDR_W = 12;
  localparam logic [7:0] RRW_IDX_CTRL = 8'h00;
  localparam logic [7:0] RRW_IDX_STATUS = 8'h01;
  localparam logic [7:0] RRW_IDX_MASK = 8'h02;
  localparam logic [7:0] RRW_IDX_RESULT = 8'h5D;
  localparam logic [7:0] RRW_IDX_ACOUSTIC = 8'h5E;
  localparam logic [7:0] RRW_IDX_MEDIA = 8'h7F;
  localparam logic [1:0] RRW_RESP_OKAY = 2'h0;
  localparam logic [1:0] RRW_RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Reset-result word fields
  // ----------------------------------------
  localparam int unsigned RRW_B_CABLE = 13;
  localparam int unsigned RRW_B_D1_PDIAG = 11;
  localparam int unsigned RRW_B_D1_METHOD = 9;
  localparam int unsigned RRW_B_ONE_HI = 8;
  localparam int unsigned RRW_B_D0_RESPONDS = 6;
  localparam int unsigned RRW_B_D0_DASP = 5;
  localparam int unsigned RRW_B_D0_PDIAG = 4;
  localparam int unsigned RRW_B_D0_DIAG = 3;
  localparam int unsigned RRW_B_D0_METHOD = 1;
  localparam int unsigned RRW_B_ONE_LO = 0;
  localparam logic [1:0] RRW_FIXED_TOP = 2'h1;
  localparam logic [13:0] RRW_RESULT_RESET = 14'h0100;
  localparam logic [1:0] RRW_METHOD_RESERVED = 2'h0;
  localparam logic [1:0] RRW_METHOD_OTHER = 2'h3;
  localparam logic [1:0] RRW_MEDIA_NONE = 2'h0;
  localparam logic [1:0] RRW_MEDIA_SUPPORTED = 2'h1;

  // ----------------------------------------
  // Control, status and mask layout
  // ----------------------------------------
  localparam int unsigned RRW_CTRL_ACOUSTIC_LSB = 0;
  localparam int unsigned RRW_CTRL_MEDIA_LSB = 8;
  localparam int unsigned RRW_CTRL_RESPONDS = 10;
  localparam logic [7:0] RRW_ACOUSTIC_RESET = 8'h00;
  localparam logic [7:0] RRW_ACOUSTIC_RECOMMENDED_DEFAULT = 8'hFE;
  localparam int unsigned RRW_EVT_W = 3;
  localparam int unsigned RRW_EVT_RESET_DONE = 0;
  localparam int unsigned RRW_EVT_ACOUSTIC = 1;
  localparam int unsigned RRW_EVT_DIAG_FAIL = 2;
  localparam logic [RRW_EVT_W-1:0] RRW_EVT_RESET = 3'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic cableAbove;
    logic cableBelow;
    logic isDevice1;
    logic otherPdiag;
    logic otherDasp;
  } rrw_pins_t;

  typedef struct packed {
    rrw_pins_t pins;
    logic selfPdiag;
    logic diagPassed;
    logic respondsForDev1;
    logic [1:0] numberMethod;
  } rrw_obs_t;

  // Reserved code 00 must never reach the word
  function automatic logic [1:0] rrw_fix_method(input logic [1:0] m);
    return (m == RRW_METHOD_RESERVED) ? RRW_METHOD_OTHER : m;
  endfunction : rrw_fix_method

  function automatic logic [RRW_ADDR_W-1:0] rrw_byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : rrw_byte_addr

endpackage : rrw_pkg

// *** rtl/rrw_identify_words.sv ***
// Operation
// - The low fourteen bits of the reset-result word change only while a hardware reset runs.
// - Bit 15 of the reset-result word reads zero, bits 14 and 8 read one.
// - Bit 13 reads one for cable-detect above the high threshold and zero below the low one.
// - Bits 12 to 8 hold the second device's result, bits 12 to 9 cleared by the first device, bit 12 reserved.
// - The second device reports in bit 11 whether it asserted the diagnostic line.
// - The second device codes in bits 10 to 9 how it chose its number, 00 never used.
// - Bits 7 to 0 hold the first device's result, cleared by the second device, bit 7 reserved.
// - The first device reports in bit 6 whether it answers while the second one is selected.
// - The first device keeps separate flags for seeing the other's presence and diagnostic lines.
// - The first device records whether its own diagnostics passed.
// - The first device codes in bits 2 to 1 how it chose its number, with the same codes.
// - The upper byte of the acoustic word is the recommended acoustic level.
// - The lower byte of the acoustic word follows the acoustic level now in effect.
// - Bits 1 to 0 of the media word report notification support, 10 never used.
`timescale 1ns/10ps
`default_nettype none
module rrw_identify_words
  import rrw_pkg::*;
#(
  parameter logic [7:0] ACOUSTIC_RECOMMENDED = RRW_ACOUSTIC_RECOMMENDED_DEFAULT
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Cable pins, asynchronous
  input wire logic hwResetPin,
  input wire logic cableAbovePin,
  input wire logic cableBelowPin,
  input wire logic device1SelectPin,
  input wire logic otherPdiagPin,
  input wire logic otherDaspPin,
  // Device logic, same clock
  input wire logic selfPdiagAsserted,
  input wire logic diagPassed,
  input wire logic [1:0] numberMethod,
  // Write address channel
  input wire logic [RRW_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [RRW_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic awHeld;
    logic [RRW_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [7:0] acousticCur;
    logic [1:0] mediaSupport;
    logic respondsForDev1;
    logic [RRW_EVT_W-1:0] status;
    logic [RRW_EVT_W-1:0] mask;
    logic hwResetPrev;
  } rrw_top_state_t;

  rrw_top_state_t state_ff;
  rrw_top_state_t nxt_state;

  rrw_pins_t pinsRaw;
  rrw_pins_t pinsSync;
  logic hwResetSync;
  rrw_obs_t obs;
  logic [15:0] resultWord;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pinsRaw = '{
    cableAbove: cableAbovePin,
    cableBelow: cableBelowPin,
    isDevice1: device1SelectPin,
    otherPdiag: otherPdiagPin,
    otherDasp: otherDaspPin
  };

  rrw_sync2 #(
    .W($bits(rrw_pins_t) + 1)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .asyncIn({pinsRaw, hwResetPin}),
    .syncOut({pinsSync, hwResetSync})
  );

  // ----------------------------------------
  // Reset-result capture
  // ----------------------------------------
  assign obs = '{
    pins: pinsSync,
    selfPdiag: selfPdiagAsserted,
    diagPassed: diagPassed,
    respondsForDev1: state_ff.respondsForDev1,
    numberMethod: numberMethod
  };

  rrw_reset_capture u_capture (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .active(hwResetSync),
    .obs(obs),
    .resultWord(resultWord)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  function automatic logic [31:0] read_word(
    input logic [RRW_ADDR_W-1:0] addr,
    input rrw_top_state_t s,
    input logic [15:0] result,
    output logic hit
  );
    logic [31:0] d;
    d = '0;
    hit = 1'b1;
    if (addr == rrw_byte_addr(RRW_IDX_RESULT)) begin
      d[15:0] = result;
    end else if (addr == rrw_byte_addr(RRW_IDX_ACOUSTIC)) begin
      d[15:0] = {ACOUSTIC_RECOMMENDED, s.acousticCur};
    end else if (addr == rrw_byte_addr(RRW_IDX_MEDIA)) begin
      d[1:0] = s.mediaSupport;
    end else if (addr == rrw_byte_addr(RRW_IDX_CTRL)) begin
      d[RRW_CTRL_ACOUSTIC_LSB +: 8] = s.acousticCur;
      d[RRW_CTRL_MEDIA_LSB +: 2] = s.mediaSupport;
      d[RRW_CTRL_RESPONDS] = s.respondsForDev1;
    end else if (addr == rrw_byte_addr(RRW_IDX_STATUS)) begin
      d[RRW_EVT_W-1:0] = s.status;
    end else if (addr == rrw_byte_addr(RRW_IDX_MASK)) begin
      d[RRW_EVT_W-1:0] = s.mask;
    end else begin
      hit = 1'b0;
    end
    return d;
  endfunction : read_word

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  // One write and one read in flight; no address is taken while an answer waits
  assign s_axi_awready = !state_ff.awHeld && !state_ff.bValid;
  assign s_axi_wready = !state_ff.wHeld && !state_ff.bValid;
  assign s_axi_arready = !state_ff.rValid;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [RRW_EVT_W-1:0] events;
    logic [31:0] rd;
    logic rdHit;
    logic [7:0] newAcoustic;
    logic [31:0] wd;
    logic [3:0] ws;
    nxt_state = state_ff;
    events = '0;
    rd = '0;
    rdHit = 1'b0;
    newAcoustic = state_ff.acousticCur;
    wd = state_ff.wData;
    ws = state_ff.wStrb;

    // End of hardware reset raises the completion events
    nxt_state.hwResetPrev = hwResetSync;
    if (state_ff.hwResetPrev && !hwResetSync) begin
      events[RRW_EVT_RESET_DONE] = 1'b1;
      // Only the first device records its own diagnostic result
      if (!pinsSync.isDevice1 && !resultWord[RRW_B_D0_DIAG]) begin
        events[RRW_EVT_DIAG_FAIL] = 1'b1;
      end
    end

    // Write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_state.awHeld = 1'b1;
      nxt_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_state.wHeld = 1'b1;
      nxt_state.wData = s_axi_wdata;
      nxt_state.wStrb = s_axi_wstrb;
    end
    if (state_ff.awHeld && state_ff.wHeld) begin
      nxt_state.awHeld = 1'b0;
      nxt_state.wHeld = 1'b0;
      nxt_state.bValid = 1'b1;
      nxt_state.bResp = RRW_RESP_OKAY;
      if (state_ff.awAddr == rrw_byte_addr(RRW_IDX_CTRL)) begin
        if (ws[0]) begin
          newAcoustic = wd[RRW_CTRL_ACOUSTIC_LSB +: 8];
        end
        if (ws[1]) begin
          // Reserved support codes are refused, old value kept
          if (wd[RRW_CTRL_MEDIA_LSB +: 2] == RRW_MEDIA_NONE ||
              wd[RRW_CTRL_MEDIA_LSB +: 2] == RRW_MEDIA_SUPPORTED) begin
            nxt_state.mediaSupport = wd[RRW_CTRL_MEDIA_LSB +: 2];
          end
          nxt_state.respondsForDev1 = wd[RRW_CTRL_RESPONDS];
        end
      end else if (state_ff.awAddr == rrw_byte_addr(RRW_IDX_MASK)) begin
        if (ws[0]) begin
          nxt_state.mask = wd[RRW_EVT_W-1:0];
        end
      end else begin
        // Identify words are read-only
        nxt_state.bResp = RRW_RESP_SLVERR;
      end
    end
    if (newAcoustic != state_ff.acousticCur) begin
      events[RRW_EVT_ACOUSTIC] = 1'b1;
    end
    nxt_state.acousticCur = newAcoustic;
    if (state_ff.bValid && s_axi_bready) begin
      nxt_state.bValid = 1'b0;
    end

    // Read channel; a status read clears it, a new event wins
    if (state_ff.rValid && s_axi_rready) begin
      nxt_state.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd = read_word(s_axi_araddr, state_ff, resultWord, rdHit);
      nxt_state.rValid = 1'b1;
      nxt_state.rData = rd;
      nxt_state.rResp = rdHit ? RRW_RESP_OKAY : RRW_RESP_SLVERR;
      if (s_axi_araddr == rrw_byte_addr(RRW_IDX_STATUS)) begin
        nxt_state.status = '0;
      end
    end
    nxt_state.status = nxt_state.status | events;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '{
        awHeld: 1'b0,
        awAddr: '0,
        wHeld: 1'b0,
        wData: '0,
        wStrb: '0,
        bValid: 1'b0,
        bResp: RRW_RESP_OKAY,
        rValid: 1'b0,
        rResp: RRW_RESP_OKAY,
        rData: '0,
        acousticCur: RRW_ACOUSTIC_RESET,
        mediaSupport: RRW_MEDIA_NONE,
        respondsForDev1: 1'b0,
        status: RRW_EVT_RESET,
        mask: RRW_EVT_RESET,
        hwResetPrev: 1'b0
      };
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_bvalid = state_ff.bValid;
  assign s_axi_bresp = state_ff.bResp;
  assign s_axi_rvalid = state_ff.rValid;
  assign s_axi_rresp = state_ff.rResp;
  assign s_axi_rdata = state_ff.rData;
  assign irq = |(state_ff.status & state_ff.mask);

endmodule : rrw_identify_words
`default_nettype wire

// *** rtl/rrw_reset_capture.sv ***
`timescale 1ns/10ps
`default_nettype none
module rrw_reset_capture
  import rrw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Observations
  input wire logic active,
  input wire rrw_obs_t obs,
  // Word
  output logic [15:0] resultWord
);

  typedef struct packed {
    logic [13:0] low;
  } rrw_cap_state_t;

  rrw_cap_state_t state_ff;
  rrw_cap_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (active) begin
      nxt_state.low[12:0] = '0;
      nxt_state.low[RRW_B_ONE_HI] = 1'b1;
      if (obs.pins.isDevice1) begin
        nxt_state.low[RRW_B_D1_PDIAG] = obs.selfPdiag;
        nxt_state.low[RRW_B_D1_METHOD +: 2] = rrw_fix_method(obs.numberMethod);
      end else begin
        nxt_state.low[RRW_B_D0_RESPONDS] = obs.respondsForDev1;
        nxt_state.low[RRW_B_D0_DASP] = obs.pins.otherDasp;
        nxt_state.low[RRW_B_D0_PDIAG] = obs.pins.otherPdiag;
        nxt_state.low[RRW_B_D0_DIAG] = obs.diagPassed;
        nxt_state.low[RRW_B_D0_METHOD +: 2] = rrw_fix_method(obs.numberMethod);
        nxt_state.low[RRW_B_ONE_LO] = 1'b1;
      end
      // Between thresholds the old level is kept
      if (obs.pins.cableAbove) begin
        nxt_state.low[RRW_B_CABLE] = 1'b1;
      end else if (obs.pins.cableBelow) begin
        nxt_state.low[RRW_B_CABLE] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= RRW_RESULT_RESET;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign resultWord = {RRW_FIXED_TOP, state_ff.low};

endmodule : rrw_reset_capture
`default_nettype wire

// *** rtl/rrw_sync2.sv ***
`timescale 1ns/10ps
`default_nettype none
module rrw_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rrw_sync_state_t;

  rrw_sync_state_t state_ff;
  rrw_sync_state_t nxt_state;

  // First stage feeds only the second stage
  always_comb begin
    nxt_state = state_ff;
    nxt_state.meta = asyncIn;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign syncOut = state_ff.stable;

endmodule : rrw_sync2
`default_nettype wire

// *** tb/reset_result_identify_words_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module reset_result_identify_words_tb_top;
  import rrw_pkg::*;
  localparam logic [11:0] A_CTRL = 12'h000, A_STAT = 12'h004, A_MASK = 12'h008;
  localparam logic [11:0] A_RES = 12'h174, A_ACO = 12'h178, A_MED = 12'h1FC;
  logic clk = 1'b0, reset = 1'b1, go = 1'b0, dev1 = 1'b0, cableHi = 1'b0;
  logic otherPd = 1'b0, otherDa = 1'b0, selfPd = 1'b0, diagOk = 1'b1;
  logic [1:0] method = 2'h1, bresp, rresp, rs;
  logic hwResetPin, cableAbovePin, cableBelowPin, device1SelectPin, otherPdiagPin, otherDaspPin;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  int num_errors = 0, cmp_count = 0;
  always #5 clk = !clk;
  rrw_cable_model i_rrw_cable_model (.clk, .go, .dev1, .cableHi, .otherPd, .otherDa,
    .hwResetPin, .cableAbovePin, .cableBelowPin, .device1SelectPin, .otherPdiagPin, .otherDaspPin);
  rrw_identify_words i_rrw_identify_words (.clk, .reset, .ce(1'b1), .hwResetPin, .cableAbovePin,
    .cableBelowPin, .device1SelectPin, .otherPdiagPin, .otherDaspPin, .selfPdiagAsserted(selfPd),
    .diagPassed(diagOk), .numberMethod(method), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Readies are sampled at the falling edge, where they are settled
  task automatic axwr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, bv;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bv = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!bv);
    bready <= 1'b0;
    // One edge between calls, so no strobe is set twice in one step
    @(posedge clk);
  endtask : axwr
  task automatic axrd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, rv;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
    @(posedge clk);
  endtask : axrd
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    axrd(a, rd, rs);
    chk(rd, e);
    chk({30'h0, rs}, {30'h0, RRW_RESP_OKAY});
  endtask : rdchk
  // Pulse a cable reset, wait for the done interrupt, then read and clear status
  task automatic hwrst(input logic [31:0] st);
    int n;
    n = 0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (!irq && n < 100);
    @(posedge clk);
    rdchk(A_STAT, st);
  endtask : hwrst
  task automatic t_init;
    rdchk(A_RES, 32'h00004100);
    rdchk(A_ACO, {16'h0, RRW_ACOUSTIC_RECOMMENDED_DEFAULT, 8'h00});
    rdchk(A_MED, 32'h0);
  endtask : t_init
  task automatic t_dev0;
    logic [31:0] e;
    for (int p = 0; p < 2; p++) begin
      axwr(A_CTRL, 32'(p) << 10, rs);
      dev1 <= 1'b0;
      cableHi <= p[0];
      otherPd <= p[0];
      otherDa <= !p[0];
      diagOk <= p[0];
      method <= 2'(p + 1);
      e = 32'h00004101 | 32'(p * 32'h2058) | 32'((1 - p) * 32'h20) | 32'((p + 1) * 2);
      hwrst({29'h0, !p[0], 2'h1});
      chk({31'h0, irq}, 32'h0);
      rdchk(A_RES, e);
      diagOk <= !diagOk;
      method <= 2'h3;
      repeat (8) @(posedge clk);
      rdchk(A_RES, e);
    end
  endtask : t_dev0
  task automatic t_dev1;
    logic [31:0] e;
    for (int m = 0; m < 4; m++) begin
      dev1 <= 1'b1;
      cableHi <= m[0];
      selfPd <= m[1];
      method <= 2'(m);
      e = 32'h00004100 | {18'h0, m[0], 1'b0, m[1], (m == 0) ? 2'h3 : 2'(m), 9'h0};
      hwrst(32'h1);
      rdchk(A_RES, e);
    end
  endtask : t_dev1
  task automatic t_refuse;
    axrd(12'h100, rd, rs);
    chk({rs, rd[29:0]}, {RRW_RESP_SLVERR, 30'h0});
    axwr(A_RES, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, {30'h0, RRW_RESP_SLVERR});
    rdchk(A_RES, 32'h00006F00);
  endtask : t_refuse
  task automatic t_acoustic;
    axwr(A_MASK, 32'h2, rs);
    axwr(A_CTRL, 32'h00000155, rs);
    chk({31'h0, irq}, 32'h1);
    rdchk(A_ACO, {16'h0, RRW_ACOUSTIC_RECOMMENDED_DEFAULT, 8'h55});
    axwr(A_CTRL, 32'h000002AA, rs);
    rdchk(A_MED, 32'h1);
    rdchk(A_ACO, {16'h0, RRW_ACOUSTIC_RECOMMENDED_DEFAULT, 8'hAA});
    rdchk(A_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
  endtask : t_acoustic
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_init();
    axwr(A_MASK, 32'h5, rs);
    t_dev0();
    t_dev1();
    t_refuse();
    t_acoustic();
    end_sim();
  end
endmodule : reset_result_identify_words_tb_top
`default_nettype wire

// *** tb/rrw_cable_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rrw_cable_model #(
  parameter int RST_CYC = 8
) (
  // Clock and setup
  input wire logic clk,
  input wire logic go,
  input wire logic dev1,
  input wire logic cableHi,
  input wire logic otherPd,
  input wire logic otherDa,
  // Cable pins
  output logic hwResetPin,
  output logic cableAbovePin,
  output logic cableBelowPin,
  output logic device1SelectPin,
  output logic otherPdiagPin,
  output logic otherDaspPin
);
  int cnt_ff = 0;
  logic tog_ff = 1'b0;
  // Released lines wander outside reset, so a stale capture shows
  always_ff @(posedge clk) begin
    tog_ff <= !tog_ff;
    cnt_ff <= go ? RST_CYC : (cnt_ff > 0 ? cnt_ff - 1 : 0);
  end
  assign hwResetPin = cnt_ff != 0;
  assign cableAbovePin = hwResetPin ? cableHi : tog_ff;
  assign cableBelowPin = hwResetPin ? !cableHi : !tog_ff;
  assign device1SelectPin = dev1;
  assign otherPdiagPin = hwResetPin ? otherPd : tog_ff;
  assign otherDaspPin = hwResetPin ? otherDa : !tog_ff;
endmodule : rrw_cable_model
`default_nettype wire

// *** tb/rrw_identify_words_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module rrw_identify_words_monitor
  import rrw_pkg::*;
#(
  parameter logic [7:0] ACOUSTIC_RECOMMENDED = RRW_ACOUSTIC_RECOMMENDED_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Read side
  input wire logic [RRW_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Write side and interrupt
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Address of the read in flight
  logic [RRW_ADDR_W-1:0] rdAddr_ff;
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rdAddr_ff <= s_axi_araddr;
    end
  end
  wire rdRes = s_axi_rvalid && (rdAddr_ff == {2'h0, RRW_IDX_RESULT, 2'h0});
  wire rdAco = s_axi_rvalid && (rdAddr_ff == {2'h0, RRW_IDX_ACOUSTIC, 2'h0});
  wire rdMed = s_axi_rvalid && (rdAddr_ff == {2'h0, RRW_IDX_MEDIA, 2'h0});
  a_word_marks: assert property (
    rdRes |-> s_axi_rdata[15:14] == 2'h1 && s_axi_rdata[8]) else $error("fixed bits wrong");
  a_device_split: assert property (
    rdRes |-> !s_axi_rdata[12] && !s_axi_rdata[7] && (s_axi_rdata[7:0] == 8'h00 || s_axi_rdata[11:9] == 3'h0))
    else $error("both device fields filled");
  // Untouched reset pattern carries no method yet
  a_method_code: assert property (
    rdRes && s_axi_rdata[13:0] != RRW_RESULT_RESET |-> s_axi_rdata[10:9] != 2'h0 || s_axi_rdata[2:1] != 2'h0)
    else $error("reserved method");
  a_acoustic_top: assert property (
    rdAco |-> s_axi_rdata[15:8] == ACOUSTIC_RECOMMENDED) else $error("recommended level wrong");
  a_media_code: assert property (
    rdMed |-> s_axi_rdata[31:1] == 31'h0) else $error("media word wrong");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("upper half not zero");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  c_result_read: cover property (rdRes);
  c_media_read: cover property (rdMed);
  c_irq_rise: cover property ($rose(irq));
endmodule : rrw_identify_words_monitor

bind rrw_identify_words rrw_identify_words_monitor #(.ACOUSTIC_RECOMMENDED(ACOUSTIC_RECOMMENDED))
  i_rrw_identify_words_monitor (.clk(clk), .reset(reset), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .irq(irq));
`default_nettype wire
